// ---- logic/rlsr_pkg.sv ----
// package for the receive link status and reinit register bank
`default_nettype none
package rlsr_pkg;
  // register byte offsets
  localparam logic [7:0] REINIT_EN_OFS   = 8'h70;
  localparam logic [7:0] STATUS_WORD_OFS = 8'h80;
  localparam logic [7:0] FIFO_FLAGS_OFS  = 8'h84;
  localparam logic [7:0] CONTROL_OFS     = 8'h88;
  localparam logic [7:0] IRQ_STATUS_OFS  = 8'h90;
  localparam logic [7:0] IRQ_MASK_OFS    = 8'h94;
  // reinit enable field positions
  localparam int REINIT_SYSREF_BIT = 0;
  localparam int REINIT_LINK_BIT   = 1;
  localparam int REINIT_FRAME_BIT  = 2;
  localparam int REINIT_EN_W       = 3;
  localparam logic [2:0] REINIT_EN_RST = 3'h0;
  // control field positions
  localparam int CTRL_SYSREF_DET_BIT = 0;
  localparam int CTRL_MANUAL_BIT     = 1;
  // status word field positions
  localparam int ST_SYSREF_PEND_BIT = 29;
  localparam int ST_REINIT_BIT      = 28;
  localparam int ST_EARLY_LSB       = 19;
  localparam int ST_LATE_LSB        = 10;
  localparam int ST_EMB_LSB         = 2;
  localparam int ST_SH_LSB          = 0;
  localparam int ARRIVAL_W          = 9;
  localparam logic [8:0] ARRIVAL_MAX = 9'h1ff; // largest count a 9-bit field shows
  // sync header encodings
  localparam logic [1:0] SH_CRC12      = 2'h0;
  localparam logic [1:0] SH_CMD_CHAN   = 2'h1;
  // fifo flag positions
  localparam int FIFO_EMPTY_LSB = 16;
  localparam int FIFO_FULL_LSB  = 0;
  // interrupt bit positions
  localparam int IRQ_FRAME_BIT  = 0;
  localparam int IRQ_LINK_BIT   = 1;
  localparam int IRQ_SYSREF_BIT = 2;
  localparam int IRQ_DONE_BIT   = 3;
  localparam int IRQ_DET_BIT    = 4;
  localparam int IRQ_W          = 5;
  localparam logic [4:0] IRQ_MASK_RST = 5'h0;
  // reinit hold time
  localparam int CLK_PERIOD_NS  = 10;
  localparam int REINIT_HOLD_NS = 200;
  localparam int REINIT_HOLD_CYC = (REINIT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] REINIT_HOLD_CNT = 8'(REINIT_HOLD_CYC);
  // reinit sequencer states
  typedef enum logic [1:0] {RLSR_IDLE, RLSR_HOLD, RLSR_WAIT_SYSREF} rlsr_state_type;
endpackage
`default_nettype wire

// ---- logic/rlsr_regs.sv ----
// receive link status and error reinit register bank with apb slave
//
// The APB slave port was left to the implementer.
`default_nettype none
module rlsr_regs
  import rlsr_pkg::*;
#(
  parameter int         LANES               = 16,
  parameter logic [7:0] MB_PER_EMB          = 8'h01,
  parameter logic [1:0] SYNC_HEADER_SETTING = SH_CRC12
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        sysref_pin,
  input  wire logic        frame_ready_err,
  input  wire logic        link_ready_err,
  input  wire logic        sysref_align_err,
  input  wire logic [8:0]  earliest_arrival,
  input  wire logic [8:0]  latest_arrival,
  input  wire logic [15:0] lane_phase_fifo_empty,
  input  wire logic [15:0] lane_phase_fifo_full,
  output logic             link_reinit,
  output logic             link_init_enable,
  output logic             irq
);

  logic                   wr_en;
  logic                   rd_setup;
  logic                   addr_hit;
  logic                   wr_reinit_en;
  logic                   wr_control;
  logic                   wr_irq_status;
  logic                   wr_irq_mask;
  logic [REINIT_EN_W-1:0] reinit_en_reg;
  logic                   sysref_det_en_reg;
  logic                   manual_req;
  logic [IRQ_W-1:0]       irq_status_reg;
  logic [IRQ_W-1:0]       irq_mask_reg;
  logic [IRQ_W-1:0]       irq_event;
  logic [IRQ_W-1:0]       irq_clear;
  logic                   sysref_s1_reg;
  logic                   sysref_s2_reg;
  logic                   sysref_s3_reg;
  logic                   sysref_rise;
  logic                   sysref_pend_reg;
  logic [LANES-1:0]       empty_s1_reg;
  logic [LANES-1:0]       empty_s2_reg;
  logic [LANES-1:0]       full_s1_reg;
  logic [LANES-1:0]       full_s2_reg;
  logic [8:0]             early_reg;
  logic [8:0]             late_reg;
  logic                   auto_trig;
  logic                   reinit_done;
  logic                   reinit_start;
  logic                   reinit_busy;
  logic                   irq_pending;
  logic [7:0]             hold_cnt_reg;
  rlsr_state_type         state_reg;
  logic [31:0]            status_word;
  logic [31:0]            fifo_word;
  logic [31:0]            rd_next;

  // apb handshake: zero wait states
  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;

  // per-register write strobes, byte lane 0 only
  assign wr_reinit_en  = wr_en & (paddr == REINIT_EN_OFS) & pstrb[0];
  assign wr_control    = wr_en & (paddr == CONTROL_OFS) & pstrb[0];
  assign wr_irq_status = wr_en & (paddr == IRQ_STATUS_OFS) & pstrb[0];
  assign wr_irq_mask   = wr_en & (paddr == IRQ_MASK_OFS) & pstrb[0];

  // address decode
  always_comb begin
    unique case (paddr)
      REINIT_EN_OFS, STATUS_WORD_OFS, FIFO_FLAGS_OFS,
      CONTROL_OFS, IRQ_STATUS_OFS, IRQ_MASK_OFS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // error flag on unmapped access phase
  assign pslverr = psel & penable & ~addr_hit;

  // reinit enable register, low byte lane only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reinit_en_reg <= REINIT_EN_RST;
    end else if (wr_reinit_en) begin
      reinit_en_reg <= pwdata[REINIT_EN_W-1:0];
    end
  end

  // control: sysref detect enable and manual reinit pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_det_en_reg <= 1'b0;
    end else if (wr_control) begin
      sysref_det_en_reg <= pwdata[CTRL_SYSREF_DET_BIT];
    end
  end

  // manual reinit is a write-one pulse, never stored
  assign manual_req = wr_control & pwdata[CTRL_MANUAL_BIT];

  // sysref pin synchroniser and edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_s1_reg <= 1'b0;
      sysref_s2_reg <= 1'b0;
      sysref_s3_reg <= 1'b0;
    end else begin
      sysref_s1_reg <= sysref_pin;
      sysref_s2_reg <= sysref_s1_reg;
      sysref_s3_reg <= sysref_s2_reg;
    end
  end

  assign sysref_rise = sysref_s2_reg & ~sysref_s3_reg;

  // per-lane fifo flag synchronisers
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          empty_s1_reg[g] <= 1'b0;
          empty_s2_reg[g] <= 1'b0;
          full_s1_reg[g]  <= 1'b0;
          full_s2_reg[g]  <= 1'b0;
        end else begin
          empty_s1_reg[g] <= lane_phase_fifo_empty[g];
          empty_s2_reg[g] <= empty_s1_reg[g];
          full_s1_reg[g]  <= lane_phase_fifo_full[g];
          full_s2_reg[g]  <= full_s1_reg[g];
        end
      end
    end
  endgenerate

  // arrival counts; the 9-bit fields top out at 511
  // so a source count of 512 cannot be carried through
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      early_reg <= 9'h0;
      late_reg  <= 9'h0;
    end else begin
      early_reg <= earliest_arrival;
      late_reg  <= latest_arrival;
    end
  end

  // gated error triggers
  assign auto_trig = (frame_ready_err  & reinit_en_reg[REINIT_FRAME_BIT])
                   | (link_ready_err   & reinit_en_reg[REINIT_LINK_BIT])
                   | (sysref_align_err & reinit_en_reg[REINIT_SYSREF_BIT]);

  // any cause that starts a reinit this cycle
  assign reinit_start = auto_trig | manual_req;

  // reinit sequencer: hold link in reset, then wait for sysref
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= RLSR_IDLE;
      hold_cnt_reg <= 8'h0;
    end else begin
      unique case (state_reg)
        RLSR_IDLE: begin
          if (reinit_start) begin
            state_reg    <= RLSR_HOLD;
            hold_cnt_reg <= REINIT_HOLD_CNT;
          end
        end
        RLSR_HOLD: begin
          if (hold_cnt_reg == 8'h1) begin
            state_reg <= RLSR_WAIT_SYSREF;
          end
          hold_cnt_reg <= hold_cnt_reg - 8'h1;
        end
        RLSR_WAIT_SYSREF: begin
          if (!sysref_pend_reg) begin
            state_reg <= RLSR_IDLE;
          end
        end
        default: begin
          state_reg <= RLSR_IDLE;
        end
      endcase
    end
  end

  assign reinit_done = (state_reg == RLSR_WAIT_SYSREF) & ~sysref_pend_reg;

  // reinit in progress while the sequencer is away from idle
  assign reinit_busy = (state_reg != RLSR_IDLE);

  // link reset output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_reinit <= 1'b0;
    end else begin
      unique case (state_reg)
        RLSR_IDLE: begin
          link_reinit <= reinit_start;
        end
        RLSR_HOLD: begin
          link_reinit <= (hold_cnt_reg != 8'h1);
        end
        default: begin
          link_reinit <= 1'b0;
        end
      endcase
    end
  end

  // sysref pending: armed at reset and by reinit, cleared by detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sysref_pend_reg <= 1'b1;
    end else if (state_reg == RLSR_HOLD) begin
      sysref_pend_reg <= 1'b1;
    end else if (sysref_rise && sysref_det_en_reg) begin
      sysref_pend_reg <= 1'b0;
    end
  end

  // link init allowed once sysref seen and no reinit running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_init_enable <= 1'b0;
    end else begin
      link_init_enable <= ~sysref_pend_reg & (state_reg == RLSR_IDLE) & ~reinit_start; // drops with link_reinit
    end
  end

  // interrupt events and write-one-to-clear, set wins
  always_comb begin
    irq_event                 = '0;
    irq_event[IRQ_FRAME_BIT]  = frame_ready_err;
    irq_event[IRQ_LINK_BIT]   = link_ready_err;
    irq_event[IRQ_SYSREF_BIT] = sysref_align_err;
    irq_event[IRQ_DONE_BIT]   = reinit_done;
    irq_event[IRQ_DET_BIT]    = sysref_rise & sysref_det_en_reg & sysref_pend_reg;
    irq_clear = '0;
    if (wr_irq_status) begin
      irq_clear = pwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (wr_irq_mask) begin
      irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  // any unmasked status bit
  assign irq_pending = |(irq_status_reg & irq_mask_reg);

  // level interrupt
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_pending;
    end
  end

  // debug status word assembly
  always_comb begin
    status_word = '0;
    status_word[ST_SYSREF_PEND_BIT] = sysref_pend_reg;
    status_word[ST_REINIT_BIT]      = reinit_busy;
    status_word[ST_EARLY_LSB +: ARRIVAL_W] = early_reg;
    status_word[ST_LATE_LSB +: ARRIVAL_W]  = late_reg;
    status_word[ST_EMB_LSB +: 8] = MB_PER_EMB;
    status_word[ST_SH_LSB +: 2]  = SYNC_HEADER_SETTING;
  end

  // lane fifo flag word
  always_comb begin
    fifo_word = '0;
    fifo_word[FIFO_EMPTY_LSB +: LANES] = empty_s2_reg;
    fifo_word[FIFO_FULL_LSB +: LANES]  = full_s2_reg;
  end

  // read mux; status words have no write path
  always_comb begin
    rd_next = '0;
    unique case (paddr)
      REINIT_EN_OFS:   rd_next[REINIT_EN_W-1:0] = reinit_en_reg;
      STATUS_WORD_OFS: rd_next = status_word;
      FIFO_FLAGS_OFS:  rd_next = fifo_word;
      CONTROL_OFS:     rd_next[CTRL_SYSREF_DET_BIT] = sysref_det_en_reg;
      IRQ_STATUS_OFS:  rd_next[IRQ_W-1:0] = irq_status_reg;
      IRQ_MASK_OFS:    rd_next[IRQ_W-1:0] = irq_mask_reg;
      default:         rd_next = '0;
    endcase
  end

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (rd_setup) begin
      prdata <= rd_next;
    end
  end

endmodule
`default_nettype wire

// ---- dv/rlsr_regs_properties.sv ----
// assertion checker for the receive link status register bank
`default_nettype none
module rlsr_props
  import rlsr_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        frame_ready_err,
  input wire logic        link_ready_err,
  input wire logic        sysref_align_err,
  input wire logic        link_reinit,
  input wire logic        link_init_enable,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // any error pulse or a completed write
  logic ev;
  logic wr;
  assign ev = frame_ready_err | link_ready_err | sysref_align_err;
  assign wr = psel & penable & pwrite;
  property p_reinit_cause; $rose(link_reinit) |-> $past(ev | wr); endproperty
  a_reinit_cause: assert property (p_reinit_cause) else $error("reinit without cause");
  property p_reinit_len; $rose(link_reinit) |-> ##19 link_reinit ##1 !link_reinit; endproperty
  a_reinit_len: assert property (p_reinit_len) else $error("reinit hold length wrong");
  property p_init_gate; link_reinit |-> !link_init_enable; endproperty
  a_init_gate: assert property (p_init_gate) else $error("init enabled during reinit");
  property p_init_rise; $rose(link_init_enable) |-> $past(!link_reinit); endproperty
  a_init_rise: assert property (p_init_rise) else $error("init rose during reinit");
  property p_irq_fall; $fell(irq) |-> $past(wr, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
  property p_mapped; psel && penable && paddr == STATUS_WORD_OFS |-> !pslverr; endproperty
  a_mapped: assert property (p_mapped) else $error("status word refused");
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_hold; !$past(psel && !penable && !pwrite) |-> $stable(prdata); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
endmodule
bind rlsr_regs rlsr_props rlsr_props_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .prdata, .pslverr, .frame_ready_err, .link_ready_err, .sysref_align_err, .link_reinit,
  .link_init_enable, .irq);
`default_nettype wire

// ---- dv/rlsr_regs_tb.sv ----
// self-checking testbench for the receive link status register bank
`default_nettype none
module rlsr_regs_tb;
  import rlsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        sysref_pin = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [2:0]  err = 3'h0;
  logic [8:0]  late = 9'h0c3;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, link_reinit, link_init_enable, irq, se;
  int          errors = 0;
  int          comparisons = 0;
  // clock
  always #5 pclk = ~pclk;
  rlsr_regs #(.MB_PER_EMB(8'h04), .SYNC_HEADER_SETTING(SH_CMD_CHAN)) rlsr_regs_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .pready, .prdata,
    .pslverr, .sysref_pin, .frame_ready_err(err[2]), .link_ready_err(err[1]),
    .sysref_align_err(err[0]), .earliest_arrival(9'h005), .latest_arrival(late),
    .lane_phase_fifo_empty(16'ha5c3), .lane_phase_fifo_full(16'h3c5a), .link_reinit,
    .link_init_enable, .irq);
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, then an idle edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // expected status word
  function automatic logic [31:0] st(input logic pend, input logic busy);
    return {2'h0, pend, busy, 9'h005, 9'h0c3, 8'h04, SH_CMD_CHAN};
  endfunction
  // one-cycle error pulse
  task automatic pulse(input logic [2:0] m);
    err <= m;
    @(posedge pclk);
    err <= 3'h0;
    @(posedge pclk);
  endtask
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (5000) @(posedge pclk);
    errors++;
    summarize();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    xfer(1'b0, REINIT_EN_OFS, 32'h0);
    check(rd, 32'h0);
    xfer(1'b0, STATUS_WORD_OFS, 32'h0);
    check(rd, st(1'b1, 1'b0));
    xfer(1'b1, STATUS_WORD_OFS, 32'hffffffff);
    xfer(1'b1, FIFO_FLAGS_OFS, 32'h0);
    xfer(1'b0, STATUS_WORD_OFS, 32'h0);
    check(rd, st(1'b1, 1'b0));
    xfer(1'b0, FIFO_FLAGS_OFS, 32'h0);
    check(rd, 32'ha5c33c5a);
    xfer(1'b0, 8'h3c, 32'h0);
    check({se, rd[30:0]}, 32'h80000000);
    xfer(1'b1, CONTROL_OFS, 32'h1);
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, REINIT_EN_OFS, 32'h1 << i);
      pulse(3'h7 & ~(3'h1 << i));
      check(32'(link_reinit), 32'h0);
      pulse(3'h1 << i);
      check(32'(link_reinit), 32'h1);
      xfer(1'b0, STATUS_WORD_OFS, 32'h0);
      check(rd, st(1'b1, 1'b1));
      repeat (24) @(posedge pclk);
      sysref_pin <= 1'b1;
      repeat (3) @(posedge pclk);
      sysref_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      xfer(1'b0, STATUS_WORD_OFS, 32'h0);
      check(rd, st(1'b0, 1'b0));
      check(32'(link_init_enable), 32'h1);
    end
    xfer(1'b1, CONTROL_OFS, 32'h3);
    check(32'(link_reinit), 32'h1);
    repeat (24) @(posedge pclk);
    xfer(1'b0, IRQ_STATUS_OFS, 32'h0);
    check(rd, 32'h1f);
    check(32'(irq), 32'h0);
    xfer(1'b1, IRQ_MASK_OFS, 32'h1f);
    @(posedge pclk);
    check(32'(irq), 32'h1);
    xfer(1'b1, IRQ_STATUS_OFS, 32'h1f);
    @(posedge pclk);
    check(32'(irq), 32'h0);
    xfer(1'b1, IRQ_MASK_OFS, 32'h1);
    pulse(3'h2);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
    pulse(3'h4);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h1);
    late <= 9'h1ff;
    @(posedge pclk);
    xfer(1'b0, STATUS_WORD_OFS, 32'h0);
    check(32'(rd[18:10]), 32'h1ff);
    summarize();
  end
endmodule
`default_nettype wire
